// ==== hdl/adcc_pkg.sv ====
// adcc_pkg: register map, field positions, reset values and codes of the
// converter control block
// assumes a 32-bit axi4-lite register bus on a single 200 MHz clock
package adcc_pkg;

   // =====================================================================
   // bus and map
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_ENABLE = 8'h00;
   localparam logic [7:0] OFF_ADC_CONTROL_B = 8'h04;
   localparam logic [7:0] OFF_WINDOW_MONITOR_CONTROL = 8'h08;
   localparam logic [7:0] OFF_SOFTWARE_TRIGGER = 8'h0c;
   localparam logic [7:0] OFF_SAMPLE = 8'h10;
   localparam logic [7:0] OFF_GAIN = 8'h14;
   localparam logic [7:0] OFF_OFFSET = 8'h18;
   localparam logic [7:0] OFF_WINDOW_LOWER_LIMIT = 8'h1c;
   localparam logic [7:0] OFF_WINDOW_UPPER_LIMIT = 8'h20;
   localparam logic [7:0] OFF_INPUT = 8'h24;
   localparam logic [7:0] OFF_STATUS = 8'h28;
   localparam logic [7:0] OFF_INTFLAG = 8'h2c;
   localparam logic [7:0] OFF_INTMASK = 8'h30;
   localparam logic [7:0] OFF_RESULT = 8'h34;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // =====================================================================
   // field positions
   localparam int ENABLE_BIT = 1;
   localparam int DIFF_BIT = 0;
   localparam int LEFT_BIT = 1;
   localparam int CONTINUOUS_CONVERSION_BIT = 2;
   localparam int CORRECTION_ENABLE_BIT = 3;
   localparam int RES_LSB = 4;
   localparam int PRESC_LSB = 8;
   localparam int FLUSH_BIT = 0;
   localparam int START_BIT = 1;
   localparam int NEG_LSB = 8;
   localparam int FLAG_RESRDY = 0;
   localparam int FLAG_WINMON = 1;

   // =====================================================================
   // reset values and counts
   localparam logic [15:0] ADC_CONTROL_B_RST = 16'h0000;
   localparam logic [2:0] WINDOW_MONITOR_CONTROL_RST = 3'h0;
   localparam logic [5:0] SAMPLE_RST = 6'h00;
   localparam logic [11:0] GAIN_RST = 12'h800;
   localparam logic [11:0] OFFSET_RST = 12'h000;
   localparam logic [15:0] LIMIT_RST = 16'h0000;
   localparam logic [15:0] INPUT_RST = 16'h0000;
   localparam logic [1:0] FLAG_RST = 2'h0;
   localparam logic [8:0] DIV_CNT_RST = 9'h000;
   localparam logic [6:0] CNT_RST = 7'h00;
   localparam logic [1:0] SYNC_TICKS = 2'h2;
   localparam int GAIN_FRAC = 11;
   localparam logic [11:0] CODE_MAX = 12'hfff;

   // =====================================================================
   // resolution and window codes
   localparam logic [1:0] RES_12 = 2'h0;
   localparam logic [1:0] RES_16 = 2'h1;
   localparam logic [1:0] RES_10 = 2'h2;
   localparam logic [1:0] RES_8 = 2'h3;
   localparam logic [2:0] WIN_OFF = 3'h0;
   localparam logic [2:0] WIN_ABOVE = 3'h1;
   localparam logic [2:0] WIN_BELOW = 3'h2;
   localparam logic [2:0] WIN_INSIDE = 3'h3;
   localparam logic [2:0] WIN_OUTSIDE = 3'h4;

endpackage : adcc_pkg

// ==== hdl/adcc_clk_if.sv ====
// adcc_clk_if: carries the prescaler code, restart and half-period tick
// assumes both ends run on aclk
`timescale 1ns/100ps
interface adcc_clk_if;
   logic [2:0] code;
   logic restart;
   logic half_tick;
   modport ctl (output code, output restart, input half_tick);
   modport div (input code, input restart, output half_tick);
endinterface : adcc_clk_if

// ==== hdl/adcc_prescaler.sv ====
// adcc_prescaler: converter clock divider giving one pulse per half period
// assumes code and restart come from logic on aclk
`timescale 1ns/100ps
module adcc_prescaler (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // divider control and tick
   adcc_clk_if.div clk_port
);
   import adcc_pkg::*;

   logic [8:0] div_cnt_reg;
   logic [8:0] half_last;

   // =====================================================================
   // divider
   // half period is 2 << code cycles, full period 4 << code
   assign half_last = 9'((10'h2 << clk_port.code) - 10'h1);

   // counter restarts at once on a flush so the next period is whole
   always_ff @(posedge aclk) begin
      if (!aresetn || clk_port.restart) begin
         div_cnt_reg <= DIV_CNT_RST;
      end else if (div_cnt_reg >= half_last) begin
         div_cnt_reg <= DIV_CNT_RST;
      end else begin
         div_cnt_reg <= div_cnt_reg + 9'h1;
      end
   end

   assign clk_port.half_tick = !clk_port.restart && (div_cnt_reg >= half_last);

   // =====================================================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_div4_period: assert property ((clk_port.half_tick && clk_port.code == 3'h0)
      ##1 (!clk_port.restart && clk_port.code == 3'h0)
      |-> !clk_port.half_tick ##1 (clk_port.half_tick || clk_port.restart))
      else $error("divide by 4 half period wrong");
   a_div512_gap: assert property ((clk_port.half_tick && clk_port.code == 3'h7
      && !clk_port.restart) |=> !clk_port.half_tick [*8])
      else $error("divide by 512 ticks too close");

endmodule : adcc_prescaler

// ==== hdl/adcc_top.sv ====
// adcc_top: converter control with axi4-lite registers, sequencer,
// correction, resolution, alignment and window monitor
// assumes an analog core on aclk that answers core_convert with core_done
// Contract
// - the sampling phase lasts sample length plus one converter half periods.
// - the converter clock is the bus clock divided by 4 to 512 per prescaler code.
// - resolution code selects a 12, 16, 10 or 8 bit result.
// - with correction enabled the 12, 10 and 8 bit results are corrected for gain and offset; the 16 bit result is the raw value.
// - correction lengthens a conversion by the low four offset bits plus one converter half periods.
// - free running starts a new conversion on completion, else one per trigger; a trigger taken in ST_SAMPLE to ST_CORRECT keeps start set, so they repeat.
// - left alignment puts the high part of the result in the upper bits.
// - differential mode converts positive minus negative input.
// - window mode 0 is off, 1 to 4 compare, 5 to 7 are reserved.
// - mode 1 flags above the lower limit, mode 2 below the upper limit.
// - mode 3 flags strictly inside the limits, mode 4 anything else.
// - writing one to start begins a conversion and clears once started; it clears only in ST_IDLE, so one taken in ST_SAMPLE to ST_CORRECT stays set.
// - flush aborts conversions, restarts the clock and resumes a pending one.
// - writes to synchronized registers set a busy flag until transferred.
// - enable-protected registers take writes only while disabled.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
module adcc_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [adcc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [adcc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // analog core
   output logic core_sample,
   output logic core_convert,
   output logic core_diff,
   output logic [4:0] core_pos_sel,
   output logic [4:0] core_neg_sel,
   input wire logic core_done,
   input wire logic [15:0] core_raw,
   // interrupt
   output logic irq
);
   import adcc_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_CORRECT, ST_DONE} adcc_state_t;

   adcc_state_t state_reg;
   logic aw_have_reg, w_have_reg, bvalid_reg, rvalid_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg, rdata_reg, wmask, rd_data, wr_old, wr_new;
   logic [3:0] wstrb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic wr_fire, rd_fire, rd_ok, wr_ok, sync_wr;
   logic enable_reg, start_reg, flush_reg, convert_reg;
   logic [15:0] adc_control_b_reg, window_lower_limit_reg, window_upper_limit_reg, input_reg, result_reg, raw_reg, res_val;
   logic [2:0] window_monitor_control_reg;
   logic [5:0] sample_reg;
   logic [11:0] gain_reg, offset_reg, sat_val, base12;
   logic [6:0] cnt_reg, smp_seen_reg;
   logic [1:0] sync_cnt_reg, flag_reg, mask_reg, flag_set;
   logic signed [13:0] corr_val;
   logic signed [26:0] prod, scaled;
   logic win_hit, half_tick, correction_enable, continuous_conversion, left_adj;
   logic [1:0] res_sel;

   // =====================================================================
   // converter clock
   adcc_clk_if clk_bus ();
   adcc_prescaler u_presc (.aclk(aclk), .aresetn(aresetn), .clk_port(clk_bus.div));
   assign clk_bus.code = adc_control_b_reg[PRESC_LSB +: 3];
   // the divider also restarts as sampling begins, so the window holds whole half periods
   assign clk_bus.restart = flush_reg || !enable_reg
      || (state_reg == ST_IDLE && start_reg)
      || (state_reg == ST_DONE && (continuous_conversion || start_reg));
   assign half_tick = clk_bus.half_tick;

   assign correction_enable = adc_control_b_reg[CORRECTION_ENABLE_BIT];
   assign continuous_conversion = adc_control_b_reg[CONTINUOUS_CONVERSION_BIT];
   assign left_adj = adc_control_b_reg[LEFT_BIT];
   assign res_sel = adc_control_b_reg[RES_LSB +: 2];

   // =====================================================================
   // axi4-lite slave: one write and one read in flight
   assign s_axi_awready = !aw_have_reg && !bvalid_reg;
   assign s_axi_wready = !w_have_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
   assign rd_fire = s_axi_arvalid && !rvalid_reg;
   assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

   // byte-lane merge of the held write data into an old value
   function automatic logic [31:0] adcc_merge(input logic [31:0] old, input logic [31:0] mask,
                                              input logic [31:0] val);
      adcc_merge = (old & ~mask) | (val & mask);
   endfunction : adcc_merge

   // address and data captured independently
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_have_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_have_reg <= 1'b0;
         end
      end
   end

   // decode of mapped write addresses and the old word that the byte lanes merge into
   always_comb begin
      wr_ok = 1'b1;
      case (awaddr_reg)
         OFF_ENABLE: wr_old = 32'(enable_reg) << ENABLE_BIT;
         OFF_ADC_CONTROL_B: wr_old = 32'(adc_control_b_reg);
         OFF_WINDOW_MONITOR_CONTROL: wr_old = 32'(window_monitor_control_reg);
         OFF_SAMPLE: wr_old = 32'(sample_reg);
         OFF_GAIN: wr_old = 32'(gain_reg);
         OFF_OFFSET: wr_old = 32'(offset_reg);
         OFF_WINDOW_LOWER_LIMIT: wr_old = 32'(window_lower_limit_reg);
         OFF_WINDOW_UPPER_LIMIT: wr_old = 32'(window_upper_limit_reg);
         OFF_INPUT: wr_old = 32'(input_reg);
         OFF_INTMASK: wr_old = 32'(mask_reg);
         OFF_SOFTWARE_TRIGGER, OFF_STATUS, OFF_INTFLAG, OFF_RESULT: wr_old = 32'h00000000;
         default: begin
            wr_old = 32'h00000000;
            wr_ok = 1'b0;
         end
      endcase
   end
   assign wr_new = adcc_merge(wr_old, wmask, wdata_reg);
   assign sync_wr = wr_fire && (awaddr_reg == OFF_ADC_CONTROL_B || awaddr_reg == OFF_WINDOW_MONITOR_CONTROL
                                || awaddr_reg == OFF_SOFTWARE_TRIGGER);

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // configuration registers; protected ones only while disabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_reg <= 1'b0;
         adc_control_b_reg <= ADC_CONTROL_B_RST;
         window_monitor_control_reg <= WINDOW_MONITOR_CONTROL_RST;
         sample_reg <= SAMPLE_RST;
         gain_reg <= GAIN_RST;
         offset_reg <= OFFSET_RST;
         window_lower_limit_reg <= LIMIT_RST;
         window_upper_limit_reg <= LIMIT_RST;
         input_reg <= INPUT_RST;
         mask_reg <= FLAG_RST;
      end else if (wr_fire) begin
         case (awaddr_reg)
            OFF_ENABLE: enable_reg <= wr_new[ENABLE_BIT];
            OFF_ADC_CONTROL_B: adc_control_b_reg <= wr_new[15:0];
            OFF_WINDOW_MONITOR_CONTROL: window_monitor_control_reg <= wr_new[2:0];
            OFF_SAMPLE: if (!enable_reg) sample_reg <= wr_new[5:0];
            OFF_GAIN: if (!enable_reg) gain_reg <= wr_new[11:0];
            OFF_OFFSET: if (!enable_reg) offset_reg <= wr_new[11:0];
            OFF_WINDOW_LOWER_LIMIT: window_lower_limit_reg <= wr_new[15:0];
            OFF_WINDOW_UPPER_LIMIT: window_upper_limit_reg <= wr_new[15:0];
            OFF_INPUT: input_reg <= wr_new[15:0];
            OFF_INTMASK: mask_reg <= wr_new[1:0];
            default: ;
         endcase
      end
   end

   // busy until two converter half periods have carried the write across
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_cnt_reg <= 2'h0;
      end else if (sync_wr) begin
         sync_cnt_reg <= SYNC_TICKS;
      end else if (half_tick && sync_cnt_reg != 2'h0) begin
         sync_cnt_reg <= sync_cnt_reg - 2'h1;
      end
   end

   // =====================================================================
   // software trigger: start is a pending request, flush lives one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_reg <= 1'b0;
      end else if (wr_fire && awaddr_reg == OFF_SOFTWARE_TRIGGER && wstrb_reg[0] && wdata_reg[START_BIT]) begin
         start_reg <= 1'b1;
      end else if (flush_reg && state_reg != ST_IDLE) begin
         start_reg <= 1'b1;
      end else if (state_reg == ST_IDLE && enable_reg && !flush_reg) begin
         start_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flush_reg <= 1'b0;
      end else begin
         flush_reg <= wr_fire && awaddr_reg == OFF_SOFTWARE_TRIGGER && wstrb_reg[0] && wdata_reg[FLUSH_BIT];
      end
   end

   // =====================================================================
   // conversion sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn || flush_reg || !enable_reg) begin
         state_reg <= ST_IDLE;
         cnt_reg <= CNT_RST;
         convert_reg <= 1'b0;
         raw_reg <= 16'h0000;
      end else begin
         convert_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               cnt_reg <= CNT_RST;
               if (start_reg) state_reg <= ST_SAMPLE;
            end
            ST_SAMPLE: begin
               if (half_tick && cnt_reg == 7'(sample_reg)) begin
                  state_reg <= ST_CONVERT;
                  convert_reg <= 1'b1;
                  cnt_reg <= CNT_RST;
               end else if (half_tick) begin
                  cnt_reg <= cnt_reg + 7'h1;
               end
            end
            ST_CONVERT: begin
               if (core_done) begin
                  raw_reg <= core_raw;
                  state_reg <= correction_enable ? ST_CORRECT : ST_DONE;
               end
            end
            ST_CORRECT: begin
               if (half_tick && cnt_reg == 7'(offset_reg[3:0])) begin
                  state_reg <= ST_DONE;
               end else if (half_tick) begin
                  cnt_reg <= cnt_reg + 7'h1;
               end
            end
            ST_DONE: begin
               cnt_reg <= CNT_RST;
               state_reg <= (continuous_conversion || start_reg) ? ST_SAMPLE : ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // core drive; the core forms pos minus neg when diff is high
   assign core_sample = state_reg == ST_SAMPLE;
   assign core_convert = convert_reg;
   assign core_diff = adc_control_b_reg[DIFF_BIT];
   assign core_pos_sel = input_reg[4:0];
   assign core_neg_sel = input_reg[NEG_LSB +: 5];

   // =====================================================================
   // result path: correction, resolution, alignment, window
   always_comb begin
      corr_val = $signed({2'b00, raw_reg[11:0]}) - $signed({{2{offset_reg[11]}}, offset_reg});
      prod = corr_val * $signed({1'b0, gain_reg});
      scaled = prod >>> GAIN_FRAC;
      if (scaled < 0) sat_val = 12'h000;
      else if (scaled > $signed({15'h0, CODE_MAX})) sat_val = CODE_MAX;
      else sat_val = scaled[11:0];
      base12 = correction_enable ? sat_val : raw_reg[11:0];
      case (res_sel)
         RES_12: res_val = left_adj ? {base12, 4'h0} : {4'h0, base12};
         RES_10: res_val = left_adj ? {base12[11:2], 6'h00} : {6'h00, base12[11:2]};
         RES_8: res_val = left_adj ? {base12[11:4], 8'h00} : {8'h00, base12[11:4]};
         default: res_val = raw_reg;
      endcase
      case (window_monitor_control_reg)
         WIN_ABOVE: win_hit = res_val > window_lower_limit_reg;
         WIN_BELOW: win_hit = res_val < window_upper_limit_reg;
         WIN_INSIDE: win_hit = res_val > window_lower_limit_reg && res_val < window_upper_limit_reg;
         WIN_OUTSIDE: win_hit = !(res_val > window_lower_limit_reg && res_val < window_upper_limit_reg);
         default: win_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) result_reg <= 16'h0000;
      else if (state_reg == ST_DONE && enable_reg && !flush_reg) result_reg <= res_val;
   end

   // =====================================================================
   // sticky flags, read of the flag register clears, set wins
   assign flag_set[FLAG_RESRDY] = state_reg == ST_DONE && enable_reg && !flush_reg;
   assign flag_set[FLAG_WINMON] = flag_set[FLAG_RESRDY] && win_hit;
   always_ff @(posedge aclk) begin
      if (!aresetn) flag_reg <= FLAG_RST;
      else if (rd_fire && s_axi_araddr == OFF_INTFLAG) flag_reg <= flag_set;
      else flag_reg <= flag_reg | flag_set;
   end
   assign irq = |(flag_reg & mask_reg);

   // =====================================================================
   // read mux and response
   always_comb begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         OFF_ENABLE: rd_data = 32'(enable_reg) << ENABLE_BIT;
         OFF_ADC_CONTROL_B: rd_data = 32'(adc_control_b_reg);
         OFF_WINDOW_MONITOR_CONTROL: rd_data = 32'(window_monitor_control_reg);
         OFF_SOFTWARE_TRIGGER: rd_data = {30'h0, start_reg, flush_reg};
         OFF_SAMPLE: rd_data = 32'(sample_reg);
         OFF_GAIN: rd_data = 32'(gain_reg);
         OFF_OFFSET: rd_data = 32'(offset_reg);
         OFF_WINDOW_LOWER_LIMIT: rd_data = 32'(window_lower_limit_reg);
         OFF_WINDOW_UPPER_LIMIT: rd_data = 32'(window_upper_limit_reg);
         OFF_INPUT: rd_data = 32'(input_reg);
         OFF_STATUS: rd_data = {30'h0, state_reg != ST_IDLE, sync_cnt_reg != 2'h0};
         OFF_INTFLAG: rd_data = 32'(flag_reg);
         OFF_INTMASK: rd_data = 32'(mask_reg);
         OFF_RESULT: rd_data = 32'(result_reg);
         default: begin
            rd_data = 32'h00000000;
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_data;
         rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // =====================================================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // sampling half periods seen, for the length check
   always_ff @(posedge aclk) begin
      if (!aresetn || state_reg != ST_SAMPLE) smp_seen_reg <= CNT_RST;
      else if (half_tick) smp_seen_reg <= smp_seen_reg + 7'h1;
   end

   sequence s_sample_end;
      state_reg == ST_SAMPLE ##1 state_reg == ST_CONVERT;
   endsequence
   sequence s_corr_entry;
      state_reg == ST_CONVERT && core_done && correction_enable && enable_reg && !flush_reg;
   endsequence

   a_sample_length: assert property (s_sample_end |-> $past(smp_seen_reg) == 7'($past(sample_reg)))
      else $error("sampling phase length wrong");
   a_corr_extra: assert property (s_corr_entry |=> state_reg == ST_CORRECT ##0 core_convert == 1'b0)
      else $error("correction phase skipped");
   a_start_clear: assert property ((state_reg == ST_IDLE && start_reg && enable_reg && !flush_reg)
      |=> !start_reg && state_reg == ST_SAMPLE && core_sample)
      else $error("start not taken or not cleared");
   a_flush_abort: assert property ($rose(flush_reg) |=> state_reg == ST_IDLE && !flush_reg)
      else $error("flush did not abort");
   a_sync_busy: assert property (sync_wr |=> sync_cnt_reg == SYNC_TICKS)
      else $error("sync busy not raised");
   a_enable_protect: assert property ((wr_fire && enable_reg && awaddr_reg == OFF_SAMPLE)
      |=> $stable(sample_reg))
      else $error("protected write taken while enabled");
   a_free_run: assert property ((state_reg == ST_DONE && continuous_conversion && enable_reg && !flush_reg)
      |=> state_reg == ST_SAMPLE)
      else $error("free run did not restart");
   a_left_align: assert property ((flag_set[FLAG_RESRDY] && left_adj && res_sel == RES_12)
      |=> result_reg[3:0] == 4'h0 && result_reg[15:4] == $past(base12))
      else $error("left alignment wrong");
   a_window_flag: assert property ((flag_set[FLAG_RESRDY] && window_monitor_control_reg == WIN_ABOVE
      && res_val > window_lower_limit_reg) |=> flag_reg[FLAG_WINMON])
      else $error("window flag not set");

endmodule : adcc_top

// ==== tb/tb_top.sv ====
// tb_top: self-checking bench for adcc_top driven over axi4-lite
// assumes the core answers each convert pulse with done one cycle later
`timescale 1ns/100ps
module tb_top;
   import adcc_pkg::*;
   // =====================================================================
   // signals
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic core_sample, core_convert, core_diff;
   logic core_done = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [4:0] core_pos_sel, core_neg_sel;
   logic [15:0] core_raw;
   logic [73:0] rows [4];
   logic [5:0] win_exp = 6'b010010;
   int miscompares = 0, check_count = 0, cyc = 0, scnt = 0;
   // =====================================================================
   // design
   adcc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_sample, .core_convert, .core_diff,
      .core_pos_sel, .core_neg_sel, .core_done, .core_raw, .irq);
   // clock
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // core answer, sampling-cycle count and timeout
   always @(posedge aclk) begin
      core_done <= core_convert;
      scnt <= scnt + int'(core_sample);
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         miscompares++;
         summarize();
      end
   end
   // =====================================================================
   // tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   // one triggered conversion, then the flags read and cleared
   task automatic conv(input logic [2:0] m, input logic e);
      wr(OFF_WINDOW_MONITOR_CONTROL, {29'h0, m});
      wr(OFF_SOFTWARE_TRIGGER, 32'h2);
      for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge aclk);
      rd(OFF_INTFLAG);
      chk(d, {30'h0, e, 1'b1});
      chk({31'h0, irq}, 32'h0);
   endtask : conv
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // =====================================================================
   // sequence: reset values, register rows, then conversions
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      core_raw = 16'h0234;
      rows = '{{OFF_ADC_CONTROL_B, 32'h73f, 32'h73f, RESP_OKAY}, {OFF_WINDOW_MONITOR_CONTROL, 32'hff, 32'h7, RESP_OKAY},
         {OFF_SAMPLE, 32'hff, 32'h3f, RESP_OKAY}, {8'h40, 32'h1234, 32'h0, RESP_SLVERR}};
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         rd(rows[i][73:66]);
         chk(d, 32'h0);
         wr(rows[i][73:66], rows[i][65:34]);
         chk({30'h0, r}, {30'h0, rows[i][1:0]});
         rd(rows[i][73:66]);
         chk(d, rows[i][33:2]);
      end
      wr(OFF_ADC_CONTROL_B, 32'h1);
      wr(OFF_SAMPLE, 32'h2);
      wr(OFF_WINDOW_LOWER_LIMIT, 32'h100);
      wr(OFF_WINDOW_UPPER_LIMIT, 32'h200);
      wr(OFF_INPUT, 32'h0305);
      wr(OFF_INTMASK, 32'h1);
      wr(OFF_ENABLE, 32'h2);
      wr(OFF_SAMPLE, 32'h5);
      rd(OFF_SAMPLE);
      chk(d, 32'h2);
      for (int m = 0; m < 6; m++) conv(m[2:0], win_exp[m]);
      chk(32'(scnt), 32'd36);
      chk({21'h0, core_diff, core_neg_sel, core_pos_sel}, {21'h0, 1'b1, 5'h3, 5'h5});
      rd(OFF_RESULT);
      chk(d, 32'h234);
      rd(OFF_SOFTWARE_TRIGGER);
      chk(d, 32'h0);
      wr(OFF_ADC_CONTROL_B, 32'h3);
      conv(3'h0, 1'b0);
      rd(OFF_RESULT);
      chk(d, 32'h2340);
      wr(OFF_ENABLE, 32'h0);
      wr(OFF_OFFSET, 32'h34);
      wr(OFF_GAIN, 32'h400);
      wr(OFF_ADC_CONTROL_B, 32'h9);
      wr(OFF_ENABLE, 32'h2);
      conv(3'h0, 1'b0);
      rd(OFF_RESULT);
      chk(d, 32'h100);
      wr(OFF_SOFTWARE_TRIGGER, 32'h2);
      wr(OFF_SOFTWARE_TRIGGER, 32'h1);
      for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge aclk);
      rd(OFF_INTFLAG);
      chk(d, 32'h1);
      summarize();
   end
endmodule : tb_top
